// ==== src/mdixc_pkg.sv ====
package mdixc_pkg;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int MDIXC_PD_BIT   = 7;
	localparam int MDIXC_AUTO_BIT = 6;
	localparam int MDIXC_PAIR_BIT = 5;
	localparam int MDIXC_DONE_BIT = 4;
	localparam int MDIXC_SEED_MSB = 3;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic       MDIXC_PD_RST      = 1'b1;
	localparam logic       MDIXC_AUTO_RST    = 1'b1;
	localparam logic       MDIXC_PAIR_RST    = 1'b0;
	localparam logic [3:0] MDIXC_SEED_RST    = 4'h0;
	localparam logic [3:0] MDIXC_SEED_DFLT   = 4'h5;
	localparam int         MDIXC_ATTEMPT_US  = 100;
	localparam int         MDIXC_CLK_MHZ     = 10;
	localparam int         MDIXC_ATTEMPT_CYC = MDIXC_ATTEMPT_US * MDIXC_CLK_MHZ;
	localparam int         MDIXC_TMR_W       = 10;

	typedef enum logic [1:0]
	{
		MDIXC_IDLE = 2'b00,
		MDIXC_RUN  = 2'b01,
		MDIXC_DONE = 2'b10
	} mdixc_state_t;

	typedef struct packed
	{
		logic       we;
		logic [15:0] wdata;
	} mdixc_wr_t;

	typedef struct packed
	{
		mdixc_state_t            state;
		logic                    pd;
		logic                    auto_switch_enable;
		logic                    pair;
		logic [3:0]              seed;
		logic [3:0]              attempt;
		logic [MDIXC_TMR_W-1:0]  tmr;
		logic [15:0]             rdata;
	} mdixc_regs_t;

endpackage : mdixc_pkg

// ==== src/mdixc_ctrl.sv ====
`timescale 1ns/1ps
module mdixc_ctrl
	import mdixc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire mdixc_wr_t   wr,
	input  wire logic        link_up,
	input  wire logic        local_aneg_en,
	input  wire logic        partner_aneg,
	output logic [15:0]      crossover_control,
	output logic             pair_crossover_state
);

	mdixc_regs_t r;
	mdixc_regs_t next_r;
	logic        link_s1;
	logic        link_s2;

	// ------------------------------------------------------------
	// Link status synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_s1 <= 1'b0;
			link_s2 <= 1'b0;
		end
		else
		begin
			link_s1 <= link_up;
			link_s2 <= link_s1;
		end
	end

	function automatic logic [3:0] eff_seed(input logic [3:0] s);
		eff_seed = (s == 4'h0) ? MDIXC_SEED_DFLT : s;
	endfunction : eff_seed

	// Seeded attempts flip relative to plain alternation
	function automatic logic attempt_pair(input logic [3:0] n, input logic [3:0] s);
		logic base;
		base = n[0];
		case (n)
			4'd9:    attempt_pair = base ^ s[3];
			4'd8:    attempt_pair = base ^ s[2];
			4'd5:    attempt_pair = base ^ s[1];
			4'd4:    attempt_pair = base ^ s[0];
			default: attempt_pair = base;
		endcase
	endfunction : attempt_pair

	logic run_ok;
	assign run_ok = local_aneg_en | (r.pd & partner_aneg);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		if (wr.we)
		begin
			next_r.pd      = wr.wdata[MDIXC_PD_BIT];
			next_r.auto_switch_enable = wr.wdata[MDIXC_AUTO_BIT];
			next_r.seed    = wr.wdata[MDIXC_SEED_MSB:0];
			if (!r.auto_switch_enable)
				next_r.pair = wr.wdata[MDIXC_PAIR_BIT];
		end
		case (r.state)
			MDIXC_IDLE:
			begin
				if (r.auto_switch_enable && run_ok)
				begin
					next_r.state   = MDIXC_RUN;
					next_r.attempt = 4'h0;
					next_r.tmr     = '0;
					next_r.pair    = attempt_pair(4'h0, eff_seed(r.seed));
				end
			end
			MDIXC_RUN:
			begin
				if (!r.auto_switch_enable)
					next_r.state = MDIXC_IDLE;
				else if (link_s2)
					next_r.state = MDIXC_DONE;
				else if (r.tmr == MDIXC_TMR_W'(MDIXC_ATTEMPT_CYC - 1))
				begin
					next_r.tmr     = '0;
					next_r.attempt = r.attempt + 4'h1;
					next_r.pair    = attempt_pair(r.attempt + 4'h1, eff_seed(r.seed));
				end
				else
					next_r.tmr = r.tmr + MDIXC_TMR_W'(1);
			end
			MDIXC_DONE:
			begin
				if (!r.auto_switch_enable || !link_s2)
					next_r.state = MDIXC_IDLE;
			end
			default: next_r.state = MDIXC_IDLE;
		endcase
		next_r.rdata = '0;
		next_r.rdata[MDIXC_PD_BIT]   = next_r.pd;
		next_r.rdata[MDIXC_AUTO_BIT] = next_r.auto_switch_enable;
		next_r.rdata[MDIXC_PAIR_BIT] = next_r.pair;
		next_r.rdata[MDIXC_DONE_BIT] = (next_r.state == MDIXC_DONE) && next_r.auto_switch_enable;
		next_r.rdata[MDIXC_SEED_MSB:0] = next_r.seed;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r.state   <= MDIXC_IDLE;
			r.pd      <= MDIXC_PD_RST;
			r.auto_switch_enable <= MDIXC_AUTO_RST;
			r.pair    <= MDIXC_PAIR_RST;
			r.seed    <= MDIXC_SEED_RST;
			r.attempt <= 4'h0;
			r.tmr     <= '0;
			r.rdata   <= 16'h00C0;
		end
		else
			r <= next_r;
	end

	assign crossover_control    = r.rdata;
	assign pair_crossover_state = r.pair;

endmodule : mdixc_ctrl

// ==== bench/mdixc_ctrl_properties.sv ====
`timescale 1ns/1ps
module mdixc_ctrl_properties
	import mdixc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire mdixc_wr_t   wr,
	input wire logic        link_up,
	input wire logic [15:0] crossover_control,
	input wire logic        pair_crossover_state
);
	wire logic [15:0] c = crossover_control;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	upper_zero_a:
		assert property (c[15:8] == 8'h00) else $error("upper");
	pair_pin_a:
		assert property (c[5] == pair_crossover_state) else $error("pin");
	field_write_a:
		assert property (wr.we |=> (c & 16'h00CF) == $past(wr.wdata & 16'h00CF)) else $error("wr");
	force_pair_a:
		assert property (wr.we && !c[6] |=> c[5] == $past(wr.wdata[5])) else $error("force");
	pair_lock_a:
		assert property (wr.we && c[6] && c[4] |=> $stable(c[5])) else $error("lock");
	done_off_a:
		assert property (!c[6] [*2] |-> !c[4]) else $error("off");
	done_cause_a:
		assert property ($rose(c[4]) |-> $past(link_up) && c[6]) else $error("cause");
	done_hold_a:
		assert property (c[4] && $past(c[4]) && !$past(wr.we) |-> $stable(c[5])) else $error("hold");
endmodule : mdixc_ctrl_properties

bind mdixc_ctrl mdixc_ctrl_properties props (.ref_clk(ref_clk), .rst_n(rst_n), .wr(wr),
	.link_up(link_up), .crossover_control(crossover_control),
	.pair_crossover_state(pair_crossover_state));

// ==== bench/mdixc_link_partner.sv ====
`timescale 1ns/1ps
module mdixc_link_partner
(
	input  wire logic ref_clk,
	input  wire logic attach,
	output logic      link_up,
	output logic      partner_aneg
);
	logic [3:0] sh = 4'h0;
	assign partner_aneg = 1'b1;
	assign link_up = sh[3];
	// Link follows the cable a few cycles late, either way
	always @(posedge ref_clk)
		sh <= #1 {sh[2:0], attach};
endmodule : mdixc_link_partner

// ==== bench/mdi_crossover_control_tb_top.sv ====
`timescale 1ns/1ps
module mdi_crossover_control_tb_top
	import mdixc_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ln = 1'b0;
	logic        att = 1'b0;
	logic        lu, pa, pr;
	logic [15:0] c;
	logic [3:0]  s;
	mdixc_wr_t   wr = '0;
	int          num_errors = 0;
	int          tests_run = 0;
	always #50 ref_clk = ~ref_clk;
	mdixc_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .wr(wr), .link_up(lu), .local_aneg_en(ln),
		.partner_aneg(pa), .crossover_control(c), .pair_crossover_state(pr));
	mdixc_link_partner lp (.ref_clk(ref_clk), .attach(att), .link_up(lu), .partner_aneg(pa));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic put(input logic [15:0] v);
		cyc(1);
		wr = {1'b1, v};
		cyc(1);
		wr.we = 1'b0;
	endtask : put
	// Pair per attempt: attempt parity, flipped by seed on 4, 5, 8, 9
	function automatic logic ep(input int k, input logic [3:0] v);
		return k[0] ^ (k == 4 ? v[0] : k == 5 ? v[1] : k == 8 ? v[2] : k == 9 ? v[3] : 1'b0);
	endfunction : ep
	task automatic close_out;
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		#6000000;
		num_errors++;
		close_out;
	end
	initial
	begin
		cyc(20);
		rst_n = 1'b1;
		chk(c, 16'h00C0);
		put(16'hFF3F);
		chk(c, 16'h000F);
		put(16'hFF3F);
		chk(c, 16'h002F);
		put(16'hFF1F);
		chk(c, 16'h000F);
		put(16'h0040);
		cyc(1500);
		chk(c, 16'h0040);
		for (int i = 0; i < 2; i++)
		begin
			s = i ? 4'hA : 4'h0;
			ln = i[0];
			put(16'h0000);
			put({8'h00, 4'hC, s});
			cyc(499);
			for (int k = 0; k < 10; k++)
			begin
				chk(c, {10'h003, ep(k, s ? s : 4'h5), 1'b0, s});
				chk({15'h0000, pr}, {15'h0000, ep(k, s ? s : 4'h5)});
				cyc(1000);
			end
			att = 1'b1;
			cyc(60);
			put({8'h00, 4'hE, s});
			cyc(1500);
			chk(c, {12'h00D, s});
			att = 1'b0;
			cyc(10);
		end
		put(16'h0000);
		cyc(2);
		chk(c, 16'h0000);
		close_out;
	end
endmodule : mdi_crossover_control_tb_top
